// ==== logic/rf_pkg.sv ====
// Purpose: Shared constants and types for the response framer.
// Assumes: One clock domain, byte-wide response stream.
// Notes: Response codes other than OK and error are local codes.
package rf_pkg;

  // Queue RAM: fixed slot per message, carved from one pool
  localparam int SLOT_BYTES = 22;
  localparam int SLOTS = 4;
  localparam int MEM_BYTES = SLOTS * SLOT_BYTES;
  localparam logic [15:0] RAM_POOL = 16'h0800;
  localparam logic [15:0] UI_RAM_FREE = 16'(RAM_POOL - 16'(MEM_BYTES));

  // Control store
  localparam int NCTL = 8;
  localparam int CIW = 3;

  // Output buffer
  localparam int FIFO_W = 8;
  localparam int FIFO_DEPTH = 4;

  // Response type codes
  localparam logic [7:0] RSP_OK = 8'h01;
  localparam logic [7:0] RSP_ERR = 8'h02;
  localparam logic [7:0] RSP_IO_VAL = 8'h10;
  localparam logic [7:0] RSP_CTL_VAL = 8'h11;
  localparam logic [7:0] RSP_CTL_MOD = 8'h12;
  localparam logic [7:0] RSP_CONN = 8'h20;
  localparam logic [7:0] RSP_DISC = 8'h21;
  localparam logic [7:0] RSP_PAIR = 8'h22;
  localparam logic [7:0] RSP_MSGBOX = 8'h23;

  // Response lengths, length byte included
  localparam logic [4:0] LEN_BASE = 5'h02;
  localparam logic [4:0] LEN_ONE = 5'h03;
  localparam logic [4:0] LEN_AN = 5'h04;
  localparam logic [4:0] LEN_MOD = 5'h04;
  localparam logic [4:0] LEN_LATCH = 5'h05;
  localparam logic [4:0] LEN_INT = 5'h08;
  localparam logic [4:0] HDR_ID = 5'h04;
  localparam logic [4:0] HDR_NOID = 5'h02;

  localparam logic [31:0] AN_MASK = 32'h0000_03ff;
  localparam logic [31:0] BIT_MASK = 32'h0000_0001;
  localparam logic [31:0] BYTE_MASK = 32'h0000_00ff;

  typedef enum logic [3:0] {
    K_OK = 4'h0,
    K_ERR = 4'h1,
    K_IO_AN = 4'h2,
    K_IO_DIG = 4'h3,
    K_CTL_VAL = 4'h4,
    K_CONN = 4'h5,
    K_DISC = 4'h6,
    K_PAIR = 4'h7,
    K_MSGBOX = 4'h8
  } rf_kind_t;

  typedef enum logic [1:0] {
    C_LATCH = 2'h0,
    C_LIST = 2'h1,
    C_NUMBER = 2'h2
  } rf_ctl_t;

  typedef enum logic [0:0] {
    B_IDLE = 1'b0,
    B_BUILD = 1'b1
  } rf_bstate_t;

endpackage

// ==== logic/rf_fifo.sv ====
// Purpose: Small valid/ready FIFO between framer and serial side.
// Assumes: Single clock, DEPTH a power of two.
// Notes: Full and empty come from one occupancy counter.
module rf_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic in_valid, // Write request
  output logic in_ready, // Space available
  input wire logic [W-1:0] in_data, // Write data
  output logic out_valid, // Data available
  input wire logic out_ready, // Read accept
  output logic [W-1:0] out_data // Head word
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_ff [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] cnt_ff;
  logic do_wr;
  logic do_rd;

  assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (do_wr && !do_rd) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

// ==== logic/rf_framer.sv ====
// Purpose: Builds server response messages, queues them, streams bytes.
// Assumes: Events arrive as valid/ready requests; serial side pulls bytes.
// Notes: Integers go out most significant byte first.
//
// Contract
// - Data indication high while responses wait
// - First byte equals total response length
// - Second byte carries the response type
// - Plain completion answers with OK code
// - Analog reply: ten-bit value, two bytes
// - Digital reply: single byte, zero or one
// - Control id in bytes three and four
// - Modified notice ends after control id
// - Latch value reply carries one byte
// - List value reply carries four bytes
// - Number value reply carries four bytes
// - Fixed slot per message; UI RAM remainder
// - Connect, disconnect, pairing get own responses
// - Remote control change raises unsolicited notice
// - Message-box answers only for newer clients
// - Host updates accepted regardless of link
// - Control states survive a link drop
// - Locked controls: host writes, remote refused
module rf_framer (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic ev_valid, // Response request
  input wire logic [3:0] ev_kind, // Request kind
  input wire logic [15:0] ev_id, // Control id
  input wire logic [31:0] ev_value, // Value or code
  output logic ev_ready_ff, // Request may be taken
  input wire logic hset_valid, // Host control update
  input wire logic [15:0] hset_id, // Host control id
  input wire logic [31:0] hset_value, // Host new value
  input wire logic [1:0] hset_type, // Control type
  input wire logic hset_lock, // Remote may not modify
  input wire logic rset_valid, // Remote control update
  input wire logic [15:0] rset_id, // Remote control id
  input wire logic [31:0] rset_value, // Remote new value
  output logic rset_ready_ff, // Remote update may be taken
  input wire logic client_v3, // Client speaks newer protocol
  output logic [7:0] tx_data, // Response byte
  output logic tx_valid, // Response byte present
  input wire logic tx_ready, // Serial side takes byte
  output logic data_ind_ff, // Response waiting
  output logic busy_ff, // Cannot take requests
  output logic link_up_ff, // Remote client connected
  output logic [15:0] ui_ram_free_ff // RAM left for UI data
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam int QW = $clog2(rf_pkg::SLOTS);
  localparam int MAW = $clog2(rf_pkg::MEM_BYTES);
  localparam int CIW_T = rf_pkg::CIW;

  logic [7:0] qmem [0:rf_pkg::MEM_BYTES-1];
  logic [31:0] ctl_val_ff [0:rf_pkg::NCTL-1];
  logic [1:0] ctl_typ_ff [0:rf_pkg::NCTL-1];
  logic ctl_lock_ff [0:rf_pkg::NCTL-1];

  rf_pkg::rf_bstate_t bst_ff;
  rf_pkg::rf_bstate_t nxt_bst;
  logic [4:0] bld_idx_ff;
  logic [4:0] bld_len_ff;
  logic [7:0] bld_type_ff;
  logic bld_hid_ff;
  logic [15:0] bld_id_ff;
  logic [31:0] bld_val_ff;
  logic [QW-1:0] tail_ff;
  logic [QW-1:0] head_ff;
  logic [QW:0] q_cnt_ff;
  logic [QW:0] nxt_q_cnt;
  logic [4:0] snd_idx_ff;

  logic rem_go;
  logic rem_ok;
  logic ev_go;
  logic c_start;
  logic [4:0] c_len;
  logic [7:0] c_type;
  logic c_hid;
  logic [15:0] c_id;
  logic [31:0] c_val;
  logic commit;
  logic [7:0] wr_byte;
  logic [MAW-1:0] wr_addr;
  logic [MAW-1:0] rd_base;
  logic [7:0] rd_byte;
  logic [7:0] rd_len;
  logic push;
  logic pop;
  logic f_in_ready;
  logic [CIW_T-1:0] ev_ci;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [MAW-1:0] slot_base(input logic [QW-1:0] s);
    slot_base = MAW'({{(MAW-QW){1'b0}}, s} * MAW'(rf_pkg::SLOT_BYTES));
  endfunction

  // Header bytes first, then value bytes most significant first
  function automatic logic [7:0] byte_at(input logic [4:0] idx, input logic [4:0] len,
                                         input logic [7:0] typ, input logic hid,
                                         input logic [15:0] id, input logic [31:0] val);
    logic [4:0] k;
    k = len - idx - 5'h01;
    if (idx == 5'h00) begin
      byte_at = {3'h0, len};
    end else if (idx == 5'h01) begin
      byte_at = typ;
    end else if (hid && idx == 5'h02) begin
      byte_at = id[15:8];
    end else if (hid && idx == 5'h03) begin
      byte_at = id[7:0];
    end else begin
      byte_at = val[{k[1:0], 3'h0} +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  assign ev_ci = ev_id[CIW_T-1:0];
  assign rem_go = rset_valid && rset_ready_ff;
  assign ev_go = ev_valid && ev_ready_ff && !rset_valid;

  assign rem_ok = rem_go && !ctl_lock_ff[rset_id[CIW_T-1:0]];

  always_comb begin
    c_start = 1'b0;
    c_len = rf_pkg::LEN_BASE;
    c_type = rf_pkg::RSP_OK;
    c_hid = 1'b0;
    c_id = ev_id;
    c_val = ev_value;
    if (rem_ok) begin
      c_start = 1'b1;
      c_len = rf_pkg::LEN_MOD;
      c_type = rf_pkg::RSP_CTL_MOD;
      c_hid = 1'b1;
      c_id = rset_id;
    end else if (ev_go) begin
      c_start = 1'b1;
      case (rf_pkg::rf_kind_t'(ev_kind))
        rf_pkg::K_OK: c_type = rf_pkg::RSP_OK;
        rf_pkg::K_ERR: begin
          c_len = rf_pkg::LEN_ONE;
          c_type = rf_pkg::RSP_ERR;
          c_val = ev_value & rf_pkg::BYTE_MASK;
        end
        rf_pkg::K_IO_AN: begin
          c_len = rf_pkg::LEN_AN;
          c_type = rf_pkg::RSP_IO_VAL;
          c_val = ev_value & rf_pkg::AN_MASK;
        end
        rf_pkg::K_IO_DIG: begin
          c_len = rf_pkg::LEN_ONE;
          c_type = rf_pkg::RSP_IO_VAL;
          c_val = ev_value & rf_pkg::BIT_MASK;
        end
        rf_pkg::K_CTL_VAL: begin
          c_type = rf_pkg::RSP_CTL_VAL;
          c_hid = 1'b1;
          c_val = ctl_val_ff[ev_ci];
          case (rf_pkg::rf_ctl_t'(ctl_typ_ff[ev_ci]))
            rf_pkg::C_LATCH: begin
              c_len = rf_pkg::LEN_LATCH;
              c_val = ctl_val_ff[ev_ci] & rf_pkg::BIT_MASK;
            end
            default: c_len = rf_pkg::LEN_INT;
          endcase
        end
        rf_pkg::K_CONN: c_type = rf_pkg::RSP_CONN;
        rf_pkg::K_DISC: c_type = rf_pkg::RSP_DISC;
        rf_pkg::K_PAIR: c_type = rf_pkg::RSP_PAIR;
        rf_pkg::K_MSGBOX: begin
          c_start = client_v3;
          c_len = rf_pkg::LEN_ONE;
          c_type = rf_pkg::RSP_MSGBOX;
          c_val = ev_value & rf_pkg::BYTE_MASK;
        end
        // Unknown kinds are swallowed rather than framed as garbage
        default: c_start = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Builder: writes one byte per cycle into the tail slot

  assign commit = (bst_ff == rf_pkg::B_BUILD) && (bld_idx_ff == bld_len_ff - 5'h01);
  assign wr_addr = slot_base(tail_ff) + MAW'(bld_idx_ff);
  assign wr_byte = byte_at(bld_idx_ff, bld_len_ff, bld_type_ff, bld_hid_ff, bld_id_ff, bld_val_ff);

  always_comb begin
    case (bst_ff)
      rf_pkg::B_IDLE: nxt_bst = c_start ? rf_pkg::B_BUILD : rf_pkg::B_IDLE;
      rf_pkg::B_BUILD: nxt_bst = commit ? rf_pkg::B_IDLE : rf_pkg::B_BUILD;
      default: nxt_bst = rf_pkg::B_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bst_ff <= rf_pkg::B_IDLE;
      bld_idx_ff <= 5'h00;
      bld_len_ff <= rf_pkg::LEN_BASE;
      bld_type_ff <= 8'h00;
      bld_hid_ff <= 1'b0;
      bld_id_ff <= 16'h0000;
      bld_val_ff <= 32'h0000_0000;
      tail_ff <= '0;
    end else begin
      bst_ff <= nxt_bst;
      if (bst_ff == rf_pkg::B_IDLE && c_start) begin
        bld_idx_ff <= 5'h00;
        bld_len_ff <= c_len;
        bld_type_ff <= c_type;
        bld_hid_ff <= c_hid;
        bld_id_ff <= c_id;
        bld_val_ff <= c_val;
      end else if (bst_ff == rf_pkg::B_BUILD) begin
        bld_idx_ff <= bld_idx_ff + 5'h01;
      end
      if (commit) begin
        tail_ff <= tail_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (bst_ff == rf_pkg::B_BUILD) begin
      qmem[wr_addr] <= wr_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sender: streams the head slot into the output FIFO

  assign rd_base = slot_base(head_ff);
  assign rd_byte = qmem[rd_base + MAW'(snd_idx_ff)];
  assign rd_len = qmem[rd_base];
  assign push = (q_cnt_ff != '0) && f_in_ready;
  assign pop = push && ({3'h0, snd_idx_ff} + 8'h01 == rd_len);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      head_ff <= '0;
      snd_idx_ff <= 5'h00;
    end else if (pop) begin
      head_ff <= head_ff + 1'b1;
      snd_idx_ff <= 5'h00;
    end else if (push) begin
      snd_idx_ff <= snd_idx_ff + 5'h01;
    end
  end

  // Output FIFO stalls the sender when the serial side is slow
  rf_fifo #(
    .W(rf_pkg::FIFO_W),
    .DEPTH(rf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(q_cnt_ff != '0),
    .in_ready(f_in_ready),
    .in_data(rd_byte),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Queue occupancy and handshake flags

  always_comb begin
    nxt_q_cnt = q_cnt_ff;
    if (commit && !pop) begin
      nxt_q_cnt = q_cnt_ff + 1'b1;
    end else if (pop && !commit) begin
      nxt_q_cnt = q_cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q_cnt_ff <= '0;
      ev_ready_ff <= 1'b0;
      rset_ready_ff <= 1'b0;
      busy_ff <= 1'b1;
      data_ind_ff <= 1'b0;
    end else begin
      q_cnt_ff <= nxt_q_cnt;
      ev_ready_ff <= (nxt_bst == rf_pkg::B_IDLE) && (nxt_q_cnt != (QW+1)'(rf_pkg::SLOTS));
      rset_ready_ff <= (nxt_bst == rf_pkg::B_IDLE) && (nxt_q_cnt != (QW+1)'(rf_pkg::SLOTS));
      busy_ff <= !((nxt_bst == rf_pkg::B_IDLE) && (nxt_q_cnt != (QW+1)'(rf_pkg::SLOTS)));
      data_ind_ff <= (nxt_q_cnt != '0) || tx_valid || push;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ui_ram_free_ff <= rf_pkg::UI_RAM_FREE;
    end else begin
      ui_ram_free_ff <= rf_pkg::UI_RAM_FREE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link state and control store

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link_up_ff <= 1'b0;
    end else if (ev_go && ev_kind == rf_pkg::K_CONN) begin
      link_up_ff <= 1'b1;
    end else if (ev_go && ev_kind == rf_pkg::K_DISC) begin
      link_up_ff <= 1'b0;
    end
  end

  for (genvar g = 0; g < rf_pkg::NCTL; g++) begin : g_ctl
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        ctl_val_ff[g] <= 32'h0000_0000;
        ctl_typ_ff[g] <= rf_pkg::C_LATCH;
        ctl_lock_ff[g] <= 1'b0;
      end else if (hset_valid && hset_id[CIW_T-1:0] == CIW_T'(g)) begin
        ctl_val_ff[g] <= hset_value;
        ctl_typ_ff[g] <= hset_type;
        ctl_lock_ff[g] <= hset_lock;
      end else if (rem_ok && rset_id[CIW_T-1:0] == CIW_T'(g)) begin
        ctl_val_ff[g] <= rset_value;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_ind_when_queued: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q_cnt_ff != '0) |-> data_ind_ff) else $error("queued response without indication");

  a_len_first_byte: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (bst_ff == rf_pkg::B_IDLE && c_start) |=> (wr_byte == {3'h0, bld_len_ff})) else
    $error("first byte is not the length");

  a_type_second: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (bst_ff == rf_pkg::B_IDLE && c_start) |=> ##1 (wr_byte == bld_type_ff && bld_idx_ff == 5'h01)) else
    $error("second byte is not the type");

  a_ok_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ev_go && ev_kind == rf_pkg::K_OK && !rset_valid) |=> (bld_type_ff == rf_pkg::RSP_OK
    && bld_len_ff == rf_pkg::LEN_BASE)) else $error("completion not answered with OK");

  a_analog_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ev_go && ev_kind == rf_pkg::K_IO_AN) |=> (bld_len_ff == 5'h04 && bld_val_ff[31:10] == '0)) else
    $error("analog reply malformed");

  a_digital_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ev_go && ev_kind == rf_pkg::K_IO_DIG) |=> (bld_len_ff == 5'h03 && bld_val_ff[31:1] == '0)) else
    $error("digital reply malformed");

  a_mod_no_value: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rem_ok |=> (bld_len_ff == 5'h04 && bld_hid_ff && bld_type_ff == rf_pkg::RSP_CTL_MOD)) else
    $error("modified notice carries value bytes");

  a_locked_refused: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rem_go && !rem_ok && !ev_valid) |=> (bst_ff == rf_pkg::B_IDLE)) else
    $error("locked control change produced a notice");

  a_msgbox_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ev_go && ev_kind == rf_pkg::K_MSGBOX && !client_v3) |=> (bst_ff == rf_pkg::B_IDLE)) else
    $error("message-box answer sent to older client");

  a_queue_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q_cnt_ff == (QW+1)'(rf_pkg::SLOTS)) |-> !ev_ready_ff && !rset_ready_ff) else
    $error("request accepted with queue full");

endmodule

// ==== test/rf_host_model.sv ====
// Purpose: Host side model that pulls response bytes off the serial port.
// Assumes: A byte moves on a clk_sys edge with tx_valid and tx_ready high.
// Notes: Random stalls exercise back-pressure; hold freezes reading.
module rf_host_model #(
  parameter int HDR_WAIT = 64
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [7:0] tx_data, // Response byte
  input wire logic tx_valid, // Byte present
  output logic tx_ready, // Byte taken
  input wire logic hold, // Stop reading
  output logic rx_stb, // One byte received
  output logic [7:0] rx_byte, // Received byte
  output logic hdr_timeout // Type byte came too late
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////
  int left;
  int wait_cnt;
  bit hdr;
  initial begin
    tx_ready = 1'b0;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
    hdr_timeout = 1'b0;
    left = 0;
    wait_cnt = 0;
    hdr = 1'b0;
  end
  // Ready moves on the falling edge only, stable over the sampling edge
  always @(negedge clk_sys) begin
    tx_ready <= !hold && rst_n && ($urandom % 4 != 0);
  end
  ////////////////////////////////////////////////////////////
  // frame by length, header first
  always @(posedge clk_sys) begin
    rx_stb <= 1'b0;
    if (tx_valid && tx_ready) begin
      rx_stb <= 1'b1;
      rx_byte <= tx_data;
      wait_cnt = 0;
      hdr = (left == 0);
      left = (left == 0) ? int'(tx_data) - 1 : left - 1;
    end else if (hdr && tx_ready) begin
      wait_cnt++;
      if (wait_cnt > HDR_WAIT) begin
        hdr_timeout <= 1'b1;
      end
    end
  end
endmodule

// ==== test/rf_framer_tb_top.sv ====
// Purpose: Self-checking bench for the response framer.
// Assumes: Inputs driven on the falling edge; host model drains bytes.
// Notes: Expected bytes come from a queue model of the control store.
module rf_framer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_n, ev_valid, hset_valid, hset_lock, rset_valid, client_v3, hold;
  logic [3:0] ev_kind;
  logic [15:0] ev_id, hset_id, rset_id, ui_ram_free_ff;
  logic [31:0] ev_value, hset_value, rset_value;
  logic [1:0] hset_type;
  logic ev_ready_ff, rset_ready_ff, tx_valid, tx_ready, data_ind_ff, busy_ff, link_up_ff, rx_stb, hdr_timeout;
  logic [7:0] tx_data, rx_byte;
  int err_total, samples_checked, cycles;
  logic [7:0] exp_q[$];
  logic [31:0] sv[8];
  logic [1:0] st[8];
  bit sl[8];
  ////////////////////////////////////////////////////////////
  rf_framer i_rf_framer (.clk_sys(clk_sys), .rst_n(rst_n), .ev_valid(ev_valid), .ev_kind(ev_kind),
    .ev_id(ev_id), .ev_value(ev_value), .ev_ready_ff(ev_ready_ff), .hset_valid(hset_valid),
    .hset_id(hset_id), .hset_value(hset_value), .hset_type(hset_type), .hset_lock(hset_lock),
    .rset_valid(rset_valid), .rset_id(rset_id), .rset_value(rset_value), .rset_ready_ff(rset_ready_ff),
    .client_v3(client_v3), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .data_ind_ff(data_ind_ff), .busy_ff(busy_ff), .link_up_ff(link_up_ff), .ui_ram_free_ff(ui_ram_free_ff));
  rf_host_model i_rf_host_model (.clk_sys(clk_sys), .rst_n(rst_n), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .hold(hold), .rx_stb(rx_stb), .rx_byte(rx_byte), .hdr_timeout(hdr_timeout));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles >= 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // Every received byte against the model, extras included
  always @(posedge clk_sys) begin
    if (rx_stb) begin
      if (exp_q.size() == 0) check(32'(rx_byte), 32'h100);
      else check(32'(rx_byte), 32'(exp_q.pop_front()));
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic model(input logic [3:0] k, input logic [15:0] id, input logic [31:0] v);
    logic [31:0] c;
    c = sv[id[2:0]];
    case (k)
      4'h0: exp_q = {exp_q, 8'h02, rf_pkg::RSP_OK};
      4'h1: exp_q = {exp_q, 8'h03, rf_pkg::RSP_ERR, v[7:0]};
      4'h2: exp_q = {exp_q, 8'h04, rf_pkg::RSP_IO_VAL, 8'(v[9:8]), v[7:0]};
      4'h3: exp_q = {exp_q, 8'h03, rf_pkg::RSP_IO_VAL, 8'(v[0])};
      4'h4: begin
        if (st[id[2:0]] == 2'h0) exp_q = {exp_q, 8'h05, rf_pkg::RSP_CTL_VAL, id[15:8], id[7:0], c[7:0]};
        else exp_q = {exp_q, 8'h08, rf_pkg::RSP_CTL_VAL, id[15:8], id[7:0], c[31:24], c[23:16], c[15:8], c[7:0]};
      end
      4'h5: exp_q = {exp_q, 8'h02, rf_pkg::RSP_CONN};
      4'h6: exp_q = {exp_q, 8'h02, rf_pkg::RSP_DISC};
      4'h7: exp_q = {exp_q, 8'h02, rf_pkg::RSP_PAIR};
      4'h8: if (client_v3) exp_q = {exp_q, 8'h03, rf_pkg::RSP_MSGBOX, v[7:0]};
      default: ;
    endcase
  endtask
  task automatic send_ev(input logic [3:0] k, input logic [15:0] id, input logic [31:0] v);
    int n;
    logic fr;
    n = 0;
    // Swallowed requests leave the port free
    fr = (k < 4'h8) || (k == 4'h8 && client_v3);
    @(negedge clk_sys);
    ev_kind = k;
    ev_id = id;
    ev_value = v;
    ev_valid = 1'b1;
    while (ev_ready_ff !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    ev_valid = 1'b0;
    check(32'(busy_ff), 32'(fr));
    check(32'(ev_ready_ff), 32'(!fr));
    model(k, id, v);
  endtask
  task automatic set_host(input logic [15:0] id, input logic [31:0] v, input logic [1:0] t, input logic lk);
    @(negedge clk_sys);
    hset_id = id;
    hset_value = v;
    hset_type = t;
    hset_lock = lk;
    hset_valid = 1'b1;
    @(negedge clk_sys);
    hset_valid = 1'b0;
    sv[id[2:0]] = v;
    st[id[2:0]] = t;
    sl[id[2:0]] = lk;
  endtask
  task automatic set_remote(input logic [15:0] id, input logic [31:0] v);
    int n;
    n = 0;
    @(negedge clk_sys);
    rset_id = id;
    rset_value = v;
    rset_valid = 1'b1;
    while (rset_ready_ff !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    rset_valid = 1'b0;
    check(32'(rset_ready_ff), 32'(sl[id[2:0]]));
    if (!sl[id[2:0]]) begin
      sv[id[2:0]] = v;
      exp_q = {exp_q, 8'h04, rf_pkg::RSP_CTL_MOD, id[15:8], id[7:0]};
    end
  endtask
  task automatic drain(input string name);
    int n;
    n = 0;
    @(negedge clk_sys);
    hold = 1'b0;
    while ((exp_q.size() != 0 || tx_valid !== 1'b0) && n < 3000) begin
      @(negedge clk_sys);
      n++;
    end
    repeat (4) @(negedge clk_sys);
    check(32'(exp_q.size()), 32'h0);
    check(32'(data_ind_ff), 32'h0);
    check(32'(hdr_timeout), 32'h0);
    $display("test %s done", name);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {ev_valid, hset_valid, hset_lock, rset_valid, client_v3, rst_n} = 6'h00;
    {ev_kind, ev_id, hset_id, rset_id, hset_type} = 54'h0;
    {ev_value, hset_value, rset_value} = 96'h0;
    hold = 1'b1;
    err_total = 0;
    samples_checked = 0;
    cycles = 0;
    for (int i = 0; i < 8; i++) begin
      sv[i] = 32'h0;
      st[i] = 2'h0;
      sl[i] = 1'b0;
    end
    void'($urandom(32'hb1f4));
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    @(negedge clk_sys);
    check(32'(ui_ram_free_ff), 32'(16'h0800 - 16'(rf_pkg::SLOT_BYTES * rf_pkg::SLOTS)));
    check(32'(link_up_ff), 32'h0);
    $display("test reset done");
    // Host held off so the queue backs up
    send_ev(4'h0, 16'h0, 32'h0);
    send_ev(4'h1, 16'h0, $urandom);
    send_ev(4'h0, 16'h0, 32'h0);
    send_ev(4'h0, 16'h0, 32'h0);
    repeat (10) @(negedge clk_sys);
    check(32'(data_ind_ff), 32'h1);
    check(32'(tx_data), 32'h2);
    drain("queue");
    for (int i = 0; i < 4; i++) begin
      send_ev(4'h2, 16'h0, (i == 0) ? 32'h0 : (i == 1) ? 32'h3ff : $urandom % 1024);
    end
    send_ev(4'h3, 16'h0, 32'h0);
    send_ev(4'h3, 16'h0, 32'h1);
    drain("io");
    send_ev(4'h5, 16'h0, 32'h0);
    check(32'(link_up_ff), 32'h1);
    send_ev(4'h7, 16'h0, 32'h0);
    send_ev(4'h6, 16'h0, 32'h0);
    check(32'(link_up_ff), 32'h0);
    send_ev(4'h8, 16'h0, $urandom);
    send_ev(4'h9, 16'h0, 32'h0);
    @(negedge clk_sys);
    client_v3 = 1'b1;
    send_ev(4'h8, 16'h0, $urandom);
    drain("link");
    // host writes with no client linked
    set_host(16'h0100, 32'h1, 2'h0, 1'b0);
    set_host(16'h0201, $urandom, 2'h1, 1'b0);
    set_host(16'h0302, $urandom, 2'h2, 1'b1);
    send_ev(4'h4, 16'h0005, 32'h0);
    send_ev(4'h4, 16'h0100, 32'h0);
    send_ev(4'h4, 16'h0201, 32'h0);
    send_ev(4'h4, 16'h0302, 32'h0);
    set_remote(16'h0201, $urandom);
    send_ev(4'h4, 16'h0201, 32'h0);
    set_remote(16'h0302, $urandom);
    send_ev(4'h4, 16'h0302, 32'h0);
    set_host(16'h0302, $urandom, 2'h2, 1'b1);
    send_ev(4'h4, 16'h0302, 32'h0);
    send_ev(4'h5, 16'h0, 32'h0);
    send_ev(4'h6, 16'h0, 32'h0);
    send_ev(4'h4, 16'h0201, 32'h0);
    drain("controls");
    tally_and_finish();
  end
endmodule
